//--- lic_pkg.sv
package lic_pkg;

  // Clock and line timing
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int LINE_RATE_KHZ = 1544;
  localparam int BIT_DIV = (CLK_FREQ_KHZ + LINE_RATE_KHZ / 2) / LINE_RATE_KHZ;

  // Data path sizes
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 16;

  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

  // Control register layout
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int FORCE_SIGNAL_LOSS_TX_BIT = 7;
  localparam int LB_LSB = 4;
  localparam int TX_DIS_BIT = 1;
  localparam int RX_DIS_BIT = 0;

  // Status register layout
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_MODE_LSB = 8;
  localparam int STAT_LOS_BIT = 10;

  // Line coding
  localparam logic [WORD_W-1:0] IDLE_WORD = 8'hFF;
  localparam logic [15:0] ENC_SUB_PATTERN = 16'h0249;
  localparam logic [7:0] DEC_MATCH_BITS = 8'h1B;
  localparam logic [7:0] DEC_MATCH_VIOL = 8'h12;

  typedef enum logic [1:0] {
    LB_NONE,
    LB_LOCAL,
    LB_REMOTE,
    LB_PAYLOAD
  } loopback_type;

  typedef enum logic [1:0] {
    SYM_ZERO,
    SYM_MARK,
    SYM_VIOL
  } symbol_type;

endpackage : lic_pkg

//--- stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  localparam int LVL_W = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  // Fill level
  output logic [LVL_W-1:0] o_level
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("stream_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [LVL_W-1:0] mem_cnt;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_type;

  fifo_state_type st;
  fifo_state_type next_st;
  logic push;
  logic load;

  // Output word sits in a register, so it counts toward the capacity
  assign o_level = LVL_W'(st.mem_cnt + LVL_W'(st.out_valid));
  assign o_in_ready = o_level < LVL_W'(DEPTH);
  assign o_out_valid = st.out_valid;
  assign o_out_data = st.out_data;
  assign push = i_in_valid & o_in_ready;
  assign load = (!st.out_valid || i_out_ready) && st.mem_cnt != '0;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = i_in_data;
      next_st.wr_ptr = PTR_W'(st.wr_ptr + 1'b1);
    end
    if (load) begin
      next_st.out_data = st.mem[st.rd_ptr];
      next_st.rd_ptr = PTR_W'(st.rd_ptr + 1'b1);
      next_st.out_valid = 1'b1;
    end else if (i_out_ready) begin
      next_st.out_valid = 1'b0;
    end
    case ({push, load})
      2'b10: next_st.mem_cnt = LVL_W'(st.mem_cnt + 1'b1);
      2'b01: next_st.mem_cnt = LVL_W'(st.mem_cnt - 1'b1);
      default: next_st.mem_cnt = st.mem_cnt;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : stream_fifo

//--- line_interface_loopback_control.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Force-loss bit 7 replaces transmit line traffic by no pulses at all.
// - Loopback field bits 5:4 selects framer loopbacks only, never unit ones.
// - Field 00: normal traffic, no loopback in either direction.
// - Field 01: transmit PCM words come back on the receive PCM output.
// - Field 01: receive line ignored, all ones sent to the line.
// - Field 10: decoded line data is re-encoded and returned to the line.
// - Field 11: received time-slot words are re-framed on transmit timing.
// - Bit 1 low enables zero substitution encoder; high sends plain AMI.
// - Bit 0 low enables zero substitution decoder; high receives plain AMI.
module line_interface_loopback_control
  import lic_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH,
  parameter int BIT_DIV_P = BIT_DIV,
  localparam int LVL_W = $clog2(FIFO_DEPTH_P + 1)
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Transmit PCM words in
  input wire logic I_TX_PCM_VALID,
  output logic O_TX_PCM_READY,
  input wire logic [WORD_W-1:0] I_TX_PCM_DATA,
  // Receive PCM words out
  output logic O_RX_PCM_VALID,
  output logic [WORD_W-1:0] O_RX_PCM_DATA,
  // Receive line pair from the line interface unit
  input wire logic I_RX_LINE_POS,
  input wire logic I_RX_LINE_NEG,
  // Transmit line pair toward the line interface unit
  output logic O_TX_LINE_POS,
  output logic O_TX_LINE_NEG
);

  if (BIT_DIV_P < 2 || BIT_DIV_P > 256) begin : g_bad_div
    $error("BIT_DIV_P must lie in 2..256");
  end
  if (FIFO_DEPTH_P < 2 || FIFO_DEPTH_P > 128) begin : g_bad_fifo
    $error("FIFO_DEPTH_P must lie in 2..128");
  end

  localparam logic [7:0] DIV_LAST = 8'(BIT_DIV_P - 1);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [31:0] prdata;
    logic [7:0] div_cnt;
    logic [2:0] bit_cnt;
    logic [WORD_W-1:0] tx_word;
    logic [WORD_W-1:0] tx_shift;
    logic [15:0] enc_sym;
    logic enc_pol;
    logic tx_pos;
    logic tx_neg;
    logic rx_pos_s1;
    logic rx_pos_s2;
    logic rx_neg_s1;
    logic rx_neg_s2;
    logic [7:0] dec_bit;
    logic [7:0] dec_viol;
    logic dec_pol;
    logic [WORD_W-1:0] rx_shift;
    logic [WORD_W-1:0] rx_word;
    logic rx_valid;
    logic [WORD_W-1:0] payload_word;
  } state_type;

  state_type st;
  state_type next_st;

  logic tick;
  logic word_edge;
  logic last_bit;
  logic force_signal_loss_tx;
  logic tx_zs_off;
  logic rx_zs_off;
  loopback_type mode;
  logic fifo_valid;
  logic fifo_pop;
  logic [WORD_W-1:0] fifo_data;
  logic [LVL_W-1:0] fifo_level;
  logic [WORD_W-1:0] load_word;
  logic ser_bit;
  logic dec_out;
  logic line_pulse;
  logic line_viol;
  logic [7:0] dec_bits_sh;
  logic [7:0] dec_viol_sh;
  logic dec_match;
  symbol_type enc_in;
  logic [15:0] enc_sh;
  logic enc_sub;
  symbol_type enc_out;
  logic pulse_pol;
  logic rx_in;
  logic apb_setup;
  logic apb_access;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    addr_hit = addr == CTRL_OFFSET || addr == STATUS_OFFSET;
  endfunction : addr_hit

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr,
                                            input logic [7:0] ctrl,
                                            input logic [LVL_W-1:0] level);
    read_word = 32'h0000_0000;
    if (addr == CTRL_OFFSET) begin
      read_word[7:0] = ctrl;
    end else if (addr == STATUS_OFFSET) begin
      read_word[STAT_LEVEL_LSB +: LVL_W] = level;
      read_word[STAT_MODE_LSB +: 2] = ctrl[LB_LSB +: 2];
      read_word[STAT_LOS_BIT] = ctrl[FORCE_SIGNAL_LOSS_TX_BIT];
    end
  endfunction : read_word

  // Back-pressure: the FIFO stalls while remote or payload loopback runs
  stream_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_tx_fifo (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_in_valid(I_TX_PCM_VALID),
    .o_in_ready(O_TX_PCM_READY),
    .i_in_data(I_TX_PCM_DATA),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data),
    .o_level(fifo_level)
  );

  assign tick = st.div_cnt == DIV_LAST;
  assign word_edge = st.bit_cnt == 3'h0;
  assign last_bit = st.bit_cnt == 3'h7;
  assign force_signal_loss_tx = st.ctrl[FORCE_SIGNAL_LOSS_TX_BIT];
  assign tx_zs_off = st.ctrl[TX_DIS_BIT];
  assign rx_zs_off = st.ctrl[RX_DIS_BIT];
  assign mode = loopback_type'(st.ctrl[LB_LSB +: 2]);
  assign fifo_pop = tick & word_edge & fifo_valid &
                    (mode == LB_NONE || mode == LB_LOCAL);
  assign load_word = (mode == LB_PAYLOAD) ? st.payload_word :
                     (fifo_valid ? fifo_data : IDLE_WORD);
  assign ser_bit = word_edge ? load_word[WORD_W-1] : st.tx_shift[WORD_W-1];
  assign dec_out = st.dec_bit[7];
  assign line_pulse = (st.rx_pos_s2 ^ st.rx_neg_s2) &
                      (mode != LB_LOCAL);
  assign line_viol = line_pulse & (st.rx_pos_s2 == st.dec_pol);
  assign dec_bits_sh = {st.dec_bit[6:0], line_pulse};
  assign dec_viol_sh = {st.dec_viol[6:0], line_viol};
  assign dec_match = !rx_zs_off && dec_bits_sh == DEC_MATCH_BITS &&
                     dec_viol_sh == DEC_MATCH_VIOL;
  assign enc_sh = {st.enc_sym[13:0], enc_in};
  assign enc_sub = !tx_zs_off && enc_sh == 16'h0000;
  assign enc_out = symbol_type'(st.enc_sym[15:14]);
  assign pulse_pol = (enc_out == SYM_VIOL) ? st.enc_pol : ~st.enc_pol;
  assign rx_in = (mode == LB_LOCAL) ? ser_bit : dec_out;
  assign apb_setup = I_PSEL & ~I_PENABLE;
  assign apb_access = I_PSEL & I_PENABLE;

  always_comb begin
    case (mode)
      LB_LOCAL: enc_in = SYM_MARK;
      LB_REMOTE: enc_in = dec_out ? SYM_MARK : SYM_ZERO;
      default: enc_in = ser_bit ? SYM_MARK : SYM_ZERO;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.div_cnt = tick ? 8'h00 : 8'(st.div_cnt + 8'h01);
    next_st.rx_pos_s1 = I_RX_LINE_POS;
    next_st.rx_pos_s2 = st.rx_pos_s1;
    next_st.rx_neg_s1 = I_RX_LINE_NEG;
    next_st.rx_neg_s2 = st.rx_neg_s1;
    next_st.rx_valid = 1'b0;
    if (apb_setup) begin
      next_st.prdata = read_word(I_PADDR, st.ctrl, fifo_level);
    end
    if (apb_access && I_PWRITE && I_PADDR == CTRL_OFFSET) begin
      next_st.ctrl = I_PWDATA[7:0];
    end
    if (tick) begin
      next_st.bit_cnt = 3'(st.bit_cnt + 3'h1);
      if (word_edge) begin
        next_st.tx_word = load_word;
        next_st.tx_shift = {load_word[WORD_W-2:0], 1'b0};
      end else begin
        next_st.tx_shift = {st.tx_shift[WORD_W-2:0], 1'b0};
      end
      next_st.enc_sym = enc_sub ? ENC_SUB_PATTERN : enc_sh;
      if (enc_out != SYM_ZERO) begin
        next_st.enc_pol = pulse_pol;
      end
      next_st.tx_pos = (enc_out != SYM_ZERO) & pulse_pol;
      next_st.tx_neg = (enc_out != SYM_ZERO) & ~pulse_pol;
      // Bipolar violations outside the pattern pass as ordinary marks
      next_st.dec_bit = dec_match ? 8'h00 : dec_bits_sh;
      next_st.dec_viol = dec_match ? 8'h00 : dec_viol_sh;
      if (line_pulse) begin
        next_st.dec_pol = st.rx_pos_s2;
      end
      next_st.rx_shift = {st.rx_shift[WORD_W-2:0], rx_in};
      if (last_bit) begin
        next_st.rx_word = {st.rx_shift[WORD_W-2:0], rx_in};
        next_st.payload_word = {st.rx_shift[WORD_W-2:0], rx_in};
        next_st.rx_valid = 1'b1;
      end
    end
    // Encoder keeps running so traffic resumes cleanly after release
    if (force_signal_loss_tx) begin
      next_st.tx_pos = 1'b0;
      next_st.tx_neg = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign O_PRDATA = st.prdata;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = apb_access & ~addr_hit(I_PADDR);
  assign O_RX_PCM_VALID = st.rx_valid;
  assign O_RX_PCM_DATA = st.rx_word;
  assign O_TX_LINE_POS = st.tx_pos;
  assign O_TX_LINE_NEG = st.tx_neg;

  // Bit ticks since the last control change, for the checks below
  logic [3:0] settle;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST || next_st.ctrl != st.ctrl) begin
      settle <= 4'h0;
    end else if (tick && settle != 4'hF) begin
      settle <= 4'(settle + 4'h1);
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  a_los_quiet: assert property (
    $past(force_signal_loss_tx) |-> !O_TX_LINE_POS && !O_TX_LINE_NEG)
    else $error("line pulses while loss of signal forced");

  a_rails_exclusive: assert property (
    !(O_TX_LINE_POS && O_TX_LINE_NEG))
    else $error("both transmit rails high");

  a_normal_fifo_word: assert property (
    tick && word_edge && mode == LB_NONE && fifo_valid
    |=> st.tx_word == $past(fifo_data))
    else $error("normal mode did not frame the queued word");

  a_local_pcm_echo: assert property (
    O_RX_PCM_VALID && mode == LB_LOCAL && settle >= 4'h9
    |-> O_RX_PCM_DATA == st.tx_word)
    else $error("local loopback word mismatch");

  a_local_all_ones: assert property (
    mode == LB_LOCAL && !force_signal_loss_tx && settle >= 4'hA
    |-> O_TX_LINE_POS ^ O_TX_LINE_NEG)
    else $error("local loopback not sending all ones");

  a_remote_echo: assert property (
    tick && mode == LB_REMOTE && !enc_sub
    |=> (st.enc_sym[1:0] == SYM_MARK) == $past(dec_out))
    else $error("remote loopback lost a decoded bit");

  a_payload_reframe: assert property (
    tick && word_edge && mode == LB_PAYLOAD
    |=> st.tx_word == $past(st.payload_word) && !$past(fifo_pop))
    else $error("payload loopback did not reframe received word");

  a_b8zs_insert: assert property (
    tick && !tx_zs_off && enc_sh == 16'h0000
    |=> st.enc_sym == ENC_SUB_PATTERN ##1 st.enc_sym == ENC_SUB_PATTERN)
    else $error("eight zeros not substituted");

  a_ami_no_subst: assert property (
    tick && tx_zs_off |=> st.enc_sym == $past(enc_sh))
    else $error("substitution while encoder disabled");

  a_b8zs_strip: assert property (
    tick && dec_match |=> st.dec_bit == 8'h00)
    else $error("substitution pattern not removed");

  a_ami_rx_keep: assert property (
    tick && rx_zs_off |=> st.dec_bit == $past(dec_bits_sh))
    else $error("decoder altered bits while disabled");

  a_ctrl_write: assert property (
    apb_access && I_PWRITE && I_PADDR == CTRL_OFFSET
    |=> st.ctrl == $past(I_PWDATA[7:0]))
    else $error("control write not stored");

  a_status_mode: assert property (
    apb_setup && !I_PWRITE && I_PADDR == STATUS_OFFSET
    |=> O_PRDATA[STAT_MODE_LSB +: 2] == $past(st.ctrl[LB_LSB +: 2]))
    else $error("status does not show loopback mode");

  c_local_word: cover property (O_RX_PCM_VALID && mode == LB_LOCAL);
  c_remote_pulse: cover property (mode == LB_REMOTE && O_TX_LINE_POS);
  c_payload_word: cover property (tick && word_edge && mode == LB_PAYLOAD);
  c_b8zs_both: cover property (tick && enc_sub ##[1:1000] tick && dec_match);
  c_fifo_full: cover property (!O_TX_PCM_READY);

endmodule : line_interface_loopback_control

//--- line_unit_model.sv
`timescale 1ns/1ps
module line_unit_model #(
  parameter int BIT_DIV_P = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Receive pattern, MSB first
  input wire logic [7:0] i_bits,
  input wire logic [7:0] i_viol,
  output logic o_rx_pos,
  output logic o_rx_neg,
  // Transmit rails seen
  input wire logic i_tx_pos,
  input wire logic i_tx_neg,
  input wire logic i_clear,
  output int o_pulses,
  output int o_viols
);
  int div;
  logic [2:0] idx;
  logic pol, last, newpol, seen;
  assign newpol = pol ^ !i_viol[idx];
  assign seen = (div == 1) && (i_tx_pos || i_tx_neg);
  // Divider in step with the block, so each level straddles its tick
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div <= 0;
      idx <= 3'h7;
      pol <= 1'b0;
      last <= 1'b0;
      o_rx_pos <= 1'b0;
      o_rx_neg <= 1'b0;
    end else begin
      div <= (div == BIT_DIV_P - 1) ? 0 : div + 1;
      if (seen) begin
        last <= i_tx_pos;
      end
      if (div == BIT_DIV_P - 1) begin
        idx <= idx - 3'h1;
        // A violation repeats the last polarity
        if (i_bits[idx]) begin
          pol <= newpol;
        end
        o_rx_pos <= i_bits[idx] && newpol;
        o_rx_neg <= i_bits[idx] && !newpol;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      o_pulses <= 0;
      o_viols <= 0;
    end else if (seen) begin
      o_pulses <= o_pulses + 1;
      o_viols <= o_viols + int'(i_tx_pos == last);
    end
  end
endmodule : line_unit_model

//--- test_line_interface_loopback_control.sv
`timescale 1ns/1ps
module test_line_interface_loopback_control;
  import lic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_ready, rx_valid;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_data;
  logic rx_pos, rx_neg, tx_pos, tx_neg;
  logic [7:0] bits = 8'hFF;
  logic [7:0] viol = 8'h00;
  logic clear = 1'b0;
  int pulses, viols;
  int fail_count = 0;
  int compares = 0;
  // Short bit period keeps each word to 32 clocks
  line_interface_loopback_control #(.FIFO_DEPTH_P(16), .BIT_DIV_P(4))
      line_interface_loopback_control_inst (
    .I_REF_CLK(clk), .I_SYS_RST(rst),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TX_PCM_VALID(tx_valid), .O_TX_PCM_READY(tx_ready),
    .I_TX_PCM_DATA(tx_data), .O_RX_PCM_VALID(rx_valid),
    .O_RX_PCM_DATA(rx_data), .I_RX_LINE_POS(rx_pos),
    .I_RX_LINE_NEG(rx_neg), .O_TX_LINE_POS(tx_pos),
    .O_TX_LINE_NEG(tx_neg));
  line_unit_model #(.BIT_DIV_P(4)) line_unit_model_inst (
    .i_clk(clk), .i_rst(rst), .i_bits(bits), .i_viol(viol),
    .o_rx_pos(rx_pos), .o_rx_neg(rx_neg), .i_tx_pos(tx_pos),
    .i_tx_neg(tx_neg), .i_clear(clear), .o_pulses(pulses),
    .o_viols(viols));
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check("apb ready", 32'h1, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r,
      output logic e);
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic rx_word(output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    while (rx_valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check("rx word wait", 32'h1, 32'(n < 100));
    d = rx_data;
  endtask : rx_word
  task automatic push(input logic [7:0] d);
    int n;
    n = 0;
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge clk);
    while (tx_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check("tx ready", 32'h1, {31'h0, tx_ready});
    tx_valid <= 1'b0;
    @(posedge clk);
  endtask : push
  task automatic measure(input int wait_cyc);
    repeat (wait_cyc) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (128) @(posedge clk);
  endtask : measure
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(CTRL_OFFSET, r, e);
    check("ctrl reset", 32'h0, r);
    wr(CTRL_OFFSET, 8'h4C);
    rd(CTRL_OFFSET, r, e);
    check("reserved readback", 32'h4C, r);
    rd(8'h08, r, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, r);
    wr(CTRL_OFFSET, 8'h00);
  endtask : t_regs
  task automatic t_rx_code();
    logic [7:0] d;
    repeat (3) rx_word(d);
    check("normal rx word", 32'hFF, {24'h0, d});
    bits <= 8'h1B;
    viol <= 8'h12;
    repeat (3) rx_word(d);
    check("decoded zeros", 32'h0, {24'h0, d});
    wr(CTRL_OFFSET, 8'h01);
    repeat (3) rx_word(d);
    // Word phase is free, so count marks, not bit places
    check("plain marks", 32'h4, 32'($countones(d)));
    wr(CTRL_OFFSET, 8'h00);
  endtask : t_rx_code
  task automatic t_fill();
    logic [31:0] r;
    logic e;
    int n;
    // Remote mode stalls the queue, so it must refuse at full depth
    wr(CTRL_OFFSET, 8'h20);
    n = 0;
    tx_valid <= 1'b1;
    @(posedge clk);
    while (tx_ready === 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    tx_valid <= 1'b0;
    check("words taken", 32'(FIFO_DEPTH), 32'(n));
    rd(STATUS_OFFSET, r, e);
    check("fill level", 32'(FIFO_DEPTH), {27'h0, r[4:0]});
    wr(CTRL_OFFSET, 8'h00);
    measure(64);
    check("zero substitution", 32'h1, 32'(viols > 0));
    n = 0;
    while (r[4:0] !== 5'h00 && n < 40) begin
      repeat (30) @(posedge clk);
      rd(STATUS_OFFSET, r, e);
      n++;
    end
    check("drained", 32'h0, {27'h0, r[4:0]});
    wr(CTRL_OFFSET, 8'h02);
    repeat (8) push(8'h00);
    measure(96);
    check("plain zeros", 32'h0, 32'(pulses));
    wr(CTRL_OFFSET, 8'h00);
  endtask : t_fill
  task automatic t_local();
    logic [31:0] r;
    logic e;
    logic [7:0] d;
    int hit, zero;
    hit = 0;
    zero = 0;
    wr(CTRL_OFFSET, 8'h10);
    repeat (2) rx_word(d);
    push(8'h3C);
    repeat (6) begin
      rx_word(d);
      hit += int'(d == 8'h3C);
      zero += int'(d == 8'h00);
    end
    check("looped word", 32'h1, 32'(hit > 0));
    check("line ignored", 32'h0, 32'(zero));
    measure(0);
    check("all ones", 32'h1, 32'(pulses >= 30));
    check("ones alternate", 32'h0, 32'(viols));
    wr(CTRL_OFFSET, 8'h90);
    measure(0);
    check("forced quiet", 32'h0, 32'(pulses));
    rd(STATUS_OFFSET, r, e);
    check("forced status", 32'h1, {31'h0, r[10]});
    wr(CTRL_OFFSET, 8'h00);
  endtask : t_local
  task automatic t_modes();
    logic [31:0] r;
    logic e;
    // Idle ones only, so the substituted input must not leak out
    measure(64);
    check("normal no loop", 32'h0, 32'(viols));
    wr(CTRL_OFFSET, 8'h20);
    measure(96);
    check("remote returns", 32'h1, 32'(viols > 0));
    rd(STATUS_OFFSET, r, e);
    check("loop field", 32'h2, {30'h0, r[9:8]});
    bits <= 8'h00;
    wr(CTRL_OFFSET, 8'h30);
    measure(128);
    check("payload resent", 32'h1, 32'(viols > 0));
    wr(CTRL_OFFSET, 8'h00);
  endtask : t_modes
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rx_code();
    t_fill();
    t_local();
    t_modes();
    test_done();
  end
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule : test_line_interface_loopback_control
